// ==== core/rom_patch_unit.sv ====
`timescale 1ns/1ns
`default_nettype none
module rom_patch_unit (
	input wire logic SYS_CLK, // 25 MHz core clock
	input wire logic RSTN, // Async reset, active low
	input wire logic WB_CYC_I, // Bus cycle
	input wire logic WB_STB_I, // Bus strobe
	input wire logic WB_WE_I, // Write enable
	input wire logic [7:0] WB_ADR_I, // Byte address
	input wire logic [3:0] WB_SEL_I, // Byte lanes
	input wire logic [31:0] WB_DAT_I, // Write data
	output logic [31:0] WB_DAT_O, // Read data
	output logic WB_ACK_O, // Cycle acknowledge
	input wire patch_pkg::word_t CORE_ADDR, // Fetch or read address
	input wire logic CORE_FETCH, // Opcode fetch this cycle
	input wire logic CORE_READ, // Data read this cycle
	input wire logic CORE_WORD, // Data read is two bytes
	input wire logic CORE_NOSUB, // Read uses HL auto inc/dec
	output logic JUMP_REQ, // Replace opcode with a jump
	output patch_pkg::word_t JUMP_ADDR, // Jump target
	output logic SUBST_VALID, // Replace read data
	output patch_pkg::word_t SUBST_DATA, // Replacement data
	output logic TRAP_INHIBIT // Suppress the address trap
);
	import patch_pkg::*;

	function automatic logic reg_hit(input logic [7:0] adr, input logic [7:0] ofs);
		reg_hit = (adr == ofs);
	endfunction

	function automatic logic in_patch_ram(input word_t a);
		in_patch_ram = (a >= RAM_FIRST) && (a <= RAM_LAST);
	endfunction

	byte_t slots [NUM_SLOTS];
	logic [3:0] ptr;
	logic [NUM_BANKS-1:0] bank_en;
	logic [NUM_BANKS-1:0] bank_mode;
	logic ack;
	logic req;
	logic wr_data;
	logic wr_ctrl;
	byte_t wr_byte;
	logic [31:0] next_rdata;
	word_t start_a [NUM_BANKS];
	word_t val_a [NUM_BANKS];
	logic [NUM_BANKS-1:0] jump_hit;
	logic [NUM_BANKS-1:0] lo_hit;
	logic [NUM_BANKS-1:0] hi_hit;
	logic next_jump;
	word_t next_jaddr;
	logic next_subst;
	word_t next_sdata;
	logic next_trap;

	bank_if bif [NUM_BANKS] ();

	// One compare lane per bank, all running every cycle
	generate
		for (genvar g = 0; g < NUM_BANKS; g++) begin : g_bank
			assign start_a[g] = {slots[g * SLOTS_PER_BANK + SLOT_ADDR_HI],
				slots[g * SLOTS_PER_BANK + SLOT_ADDR_LO]};
			assign val_a[g] = {slots[g * SLOTS_PER_BANK + SLOT_VAL_HI],
				slots[g * SLOTS_PER_BANK + SLOT_VAL_LO]};
			assign bif[g].start = start_a[g];
			assign bif[g].addr = CORE_ADDR;
			assign bif[g].en = bank_en[g];
			assign bif[g].mode = bank_mode[g];
			assign bif[g].fetch = CORE_FETCH;
			assign bif[g].read = CORE_READ;
			assign bif[g].word = CORE_WORD;
			assign bif[g].nosub = CORE_NOSUB;
			bank_match u_match (
				.bus(bif[g])
			);
			assign jump_hit[g] = bif[g].jump_hit;
			assign lo_hit[g] = bif[g].lo_hit;
			assign hi_hit[g] = bif[g].hi_hit;
		end
	endgenerate

	// Bus slave: every access is answered one cycle after it is presented
	assign req = WB_CYC_I && WB_STB_I && !ack;
	assign wr_byte = WB_DAT_I[7:0];
	assign wr_data = req && WB_WE_I && WB_SEL_I[0] && reg_hit(WB_ADR_I, OFS_DATA);
	assign wr_ctrl = req && WB_WE_I && WB_SEL_I[0] && reg_hit(WB_ADR_I, OFS_CTRL);

	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			ack <= 1'b0;
		end else begin
			ack <= req;
		end
	end

	assign WB_ACK_O = ack;

	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			ptr <= PTR_RESET;
		end else if (wr_data) begin
			// Four-bit pointer rolls from slot 15 back to slot 0 by itself
			ptr <= ptr + PTR_STEP;
		end
	end

	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			for (int i = 0; i < NUM_SLOTS; i++) begin
				slots[i] <= BYTE_ZERO;
			end
		end else if (wr_data) begin
			slots[ptr] <= wr_byte;
		end
	end

	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			bank_en <= CTRL_RESET[CTRL_EN_LSB +: NUM_BANKS];
			bank_mode <= CTRL_RESET[CTRL_MODE_LSB +: NUM_BANKS];
		end else if (wr_ctrl) begin
			bank_en <= wr_byte[CTRL_EN_LSB +: NUM_BANKS];
			bank_mode <= wr_byte[CTRL_MODE_LSB +: NUM_BANKS];
		end
	end

	// Read mux; unmapped offsets answer with zero rather than stalling the bus
	always_comb begin
		next_rdata = BUS_ZERO;
		if (reg_hit(WB_ADR_I, OFS_CTRL)) begin
			next_rdata[CTRL_EN_LSB +: NUM_BANKS] = bank_en;
			next_rdata[CTRL_MODE_LSB +: NUM_BANKS] = bank_mode;
		end else if (reg_hit(WB_ADR_I, OFS_DATA)) begin
			next_rdata[7:0] = slots[ptr];
		end else if (reg_hit(WB_ADR_I, OFS_PTR)) begin
			next_rdata[3:0] = ptr;
		end
	end

	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			WB_DAT_O <= BUS_ZERO;
		end else if (req && !WB_WE_I) begin
			WB_DAT_O <= next_rdata;
		end else begin
			WB_DAT_O <= BUS_ZERO;
		end
	end

	// Core side: lowest-numbered bank wins if software overlaps banks.
	// Results appear one cycle after the address, so the core must
	// leave that cycle free before consuming the opcode or data.
	always_comb begin
		next_jump = 1'b0;
		next_jaddr = WORD_ZERO;
		next_subst = 1'b0;
		next_sdata = WORD_ZERO;
		for (int i = NUM_BANKS - 1; i >= 0; i--) begin
			if (jump_hit[i]) begin
				next_jump = 1'b1;
				next_jaddr = val_a[i];
			end
			if (lo_hit[i]) begin
				next_subst = 1'b1;
				next_sdata = {BYTE_ZERO, val_a[i][7:0]};
			end
			if (hi_hit[i]) begin
				next_sdata[15:8] = val_a[i][15:8];
			end
		end
		next_trap = CORE_FETCH && (|bank_en) && in_patch_ram(CORE_ADDR);
	end

	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			JUMP_REQ <= 1'b0;
			JUMP_ADDR <= WORD_ZERO;
		end else begin
			JUMP_REQ <= next_jump;
			JUMP_ADDR <= next_jaddr;
		end
	end

	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			SUBST_VALID <= 1'b0;
			SUBST_DATA <= WORD_ZERO;
		end else begin
			SUBST_VALID <= next_subst;
			SUBST_DATA <= next_sdata;
		end
	end

	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			TRAP_INHIBIT <= 1'b0;
		end else begin
			TRAP_INHIBIT <= next_trap;
		end
	end

	// Checks
	byte_t past_byte;
	assign past_byte = wr_byte;

	property p_ptr_reset;
		@(posedge SYS_CLK) disable iff (!RSTN)
		$rose(RSTN) |-> (ptr == PTR_RESET);
	endproperty
	a_ptr_reset: assert property (p_ptr_reset) else $error("pointer not zero after reset");

	property p_ptr_step;
		@(posedge SYS_CLK) disable iff (!RSTN)
		(wr_data && ptr != PTR_LAST) |=> (ptr == $past(ptr) + PTR_STEP);
	endproperty
	a_ptr_step: assert property (p_ptr_step) else $error("pointer did not advance");

	property p_ptr_wrap;
		@(posedge SYS_CLK) disable iff (!RSTN)
		(wr_data && ptr == PTR_LAST) |=> (ptr == PTR_RESET);
	endproperty
	a_ptr_wrap: assert property (p_ptr_wrap) else $error("pointer did not wrap");

	property p_slot_store;
		@(posedge SYS_CLK) disable iff (!RSTN)
		wr_data |=> (slots[$past(ptr)] == $past(past_byte));
	endproperty
	a_slot_store: assert property (p_slot_store) else $error("byte not stored at slot");

	property p_jump0;
		@(posedge SYS_CLK) disable iff (!RSTN)
		(CORE_FETCH && bank_en[0] && bank_mode[0] == MODE_JUMP && CORE_ADDR == start_a[0])
			|=> (JUMP_REQ && JUMP_ADDR == $past(val_a[0]));
	endproperty
	a_jump0: assert property (p_jump0) else $error("jump not issued for bank 0");

	property p_word0;
		@(posedge SYS_CLK) disable iff (!RSTN)
		(CORE_READ && CORE_WORD && !CORE_NOSUB && bank_en[0] && bank_mode[0] == MODE_DATA
			&& CORE_ADDR == start_a[0]) |=> (SUBST_VALID && SUBST_DATA == $past(val_a[0]));
	endproperty
	a_word0: assert property (p_word0) else $error("word not replaced for bank 0");

	property p_byte_lo;
		@(posedge SYS_CLK) disable iff (!RSTN)
		(lo_hit != '0 && !CORE_WORD) |=> (SUBST_VALID && SUBST_DATA[15:8] == BYTE_ZERO);
	endproperty
	a_byte_lo: assert property (p_byte_lo) else $error("byte read got a full word");

	property p_byte_hi0;
		@(posedge SYS_CLK) disable iff (!RSTN)
		(CORE_READ && !CORE_WORD && bank_en[0] && bank_mode[0] == MODE_DATA && lo_hit == '0
			&& CORE_ADDR == start_a[0] + ADDR_STEP) |=> !SUBST_VALID;
	endproperty
	a_byte_hi0: assert property (p_byte_hi0) else $error("byte read past start substituted");

	property p_nosub;
		@(posedge SYS_CLK) disable iff (!RSTN)
		(CORE_NOSUB && !CORE_FETCH) |=> !SUBST_VALID;
	endproperty
	a_nosub: assert property (p_nosub) else $error("auto inc/dec read substituted");

	property p_disabled;
		@(posedge SYS_CLK) disable iff (!RSTN)
		(bank_en == '0) |=> (!JUMP_REQ && !SUBST_VALID && !TRAP_INHIBIT);
	endproperty
	a_disabled: assert property (p_disabled) else $error("disabled unit acted");

	property p_trap;
		@(posedge SYS_CLK) disable iff (!RSTN)
		(CORE_FETCH && bank_en != '0 && CORE_ADDR >= RAM_FIRST && CORE_ADDR <= RAM_LAST)
			|=> TRAP_INHIBIT;
	endproperty
	a_trap: assert property (p_trap) else $error("trap not suppressed in patch RAM");

	property p_ack;
		@(posedge SYS_CLK) disable iff (!RSTN)
		(WB_CYC_I && WB_STB_I && !WB_ACK_O) |=> WB_ACK_O ##1 !WB_ACK_O;
	endproperty
	a_ack: assert property (p_ack) else $error("bus ack not a single cycle");

	property p_ctrl_load;
		@(posedge SYS_CLK) disable iff (!RSTN)
		wr_ctrl |=> (bank_en == $past(wr_byte[CTRL_EN_LSB +: NUM_BANKS])
			&& bank_mode == $past(wr_byte[CTRL_MODE_LSB +: NUM_BANKS]));
	endproperty
	a_ctrl_load: assert property (p_ctrl_load) else $error("control byte not loaded");

	property p_lane_off;
		@(posedge SYS_CLK) disable iff (!RSTN)
		(req && WB_WE_I && !WB_SEL_I[0]) |=> $stable(ptr);
	endproperty
	a_lane_off: assert property (p_lane_off) else $error("masked write moved pointer");

	property p_fetch_nosubst;
		@(posedge SYS_CLK) disable iff (!RSTN)
		(CORE_FETCH && !CORE_READ) |=> !SUBST_VALID;
	endproperty
	a_fetch_nosubst: assert property (p_fetch_nosubst) else $error("fetch got data");

	property p_read_nojump;
		@(posedge SYS_CLK) disable iff (!RSTN)
		!CORE_FETCH |=> !JUMP_REQ;
	endproperty
	a_read_nojump: assert property (p_read_nojump) else $error("jump without fetch");

	property p_trap_off;
		@(posedge SYS_CLK) disable iff (!RSTN)
		!(CORE_FETCH && CORE_ADDR >= RAM_FIRST && CORE_ADDR <= RAM_LAST) |=> !TRAP_INHIBIT;
	endproperty
	a_trap_off: assert property (p_trap_off) else $error("trap suppressed outside RAM");

	property p_rd_idle;
		@(posedge SYS_CLK) disable iff (!RSTN)
		!WB_ACK_O |-> (WB_DAT_O == BUS_ZERO);
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside ack");

	property p_ptr_read;
		@(posedge SYS_CLK) disable iff (!RSTN)
		(req && !WB_WE_I && reg_hit(WB_ADR_I, OFS_PTR)) |=> (WB_DAT_O[3:0] == $past(ptr));
	endproperty
	a_ptr_read: assert property (p_ptr_read) else $error("pointer read wrong");

	property p_data_read;
		@(posedge SYS_CLK) disable iff (!RSTN)
		(req && !WB_WE_I && reg_hit(WB_ADR_I, OFS_DATA))
			|=> (WB_DAT_O[7:0] == $past(slots[ptr]) && $stable(ptr));
	endproperty
	a_data_read: assert property (p_data_read) else $error("data port read wrong");

endmodule
`default_nettype wire

// ==== common/patch_pkg.sv ====
package patch_pkg;
	typedef logic [15:0] word_t;
	typedef logic [7:0] byte_t;
	localparam int NUM_BANKS = 4;
	localparam int SLOTS_PER_BANK = 4;
	localparam int NUM_SLOTS = NUM_BANKS * SLOTS_PER_BANK;
	// Byte slot order inside one bank
	localparam int SLOT_ADDR_LO = 0;
	localparam int SLOT_ADDR_HI = 1;
	localparam int SLOT_VAL_LO = 2;
	localparam int SLOT_VAL_HI = 3;
	// Register byte offsets on the bus
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_DATA = 8'h04;
	localparam logic [7:0] OFS_PTR = 8'h08;
	// Control register fields
	localparam int CTRL_EN_LSB = 0;
	localparam int CTRL_MODE_LSB = 4;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic MODE_JUMP = 1'b0;
	localparam logic MODE_DATA = 1'b1;
	localparam logic [3:0] PTR_RESET = 4'h0;
	localparam logic [3:0] PTR_STEP = 4'h1;
	localparam logic [3:0] PTR_LAST = 4'hF;
	localparam byte_t BYTE_ZERO = 8'h00;
	localparam word_t ADDR_STEP = 16'h0001;
	localparam word_t WORD_ZERO = 16'h0000;
	localparam logic [31:0] BUS_ZERO = 32'h00000000;
	// Patch RAM window where fetches must not trap
	localparam word_t RAM_FIRST = 16'h0140;
	localparam word_t RAM_LAST = 16'h023F;
endpackage

// ==== common/bank_if.sv ====
`timescale 1ns/1ns
`default_nettype none
interface bank_if;
	import patch_pkg::*;
	word_t start;
	word_t addr;
	logic en;
	logic mode;
	logic fetch;
	logic read;
	logic word;
	logic nosub;
	logic jump_hit;
	logic lo_hit;
	logic hi_hit;
	modport table_side (output start, addr, en, mode, fetch, read, word, nosub,
		input jump_hit, lo_hit, hi_hit);
	modport match (input start, addr, en, mode, fetch, read, word, nosub,
		output jump_hit, lo_hit, hi_hit);
endinterface
`default_nettype wire

// ==== core/bank_match.sv ====
`timescale 1ns/1ns
`default_nettype none
module bank_match (
	bank_if.match bus // One bank's compare lanes
);
	import patch_pkg::*;
	logic at_start;
	logic data_rd;
	assign at_start = (bus.addr == bus.start);
	// Auto-increment/decrement reads bypass substitution entirely
	assign data_rd = bus.en && (bus.mode == MODE_DATA) && bus.read && !bus.nosub;
	assign bus.jump_hit = bus.en && (bus.mode == MODE_JUMP) && bus.fetch && at_start;
	assign bus.lo_hit = data_rd && at_start;
	// A byte read at start plus one keeps ROM data; only a word read at start reaches it
	assign bus.hi_hit = data_rd && bus.word && at_start;
endmodule
`default_nettype wire

// ==== tb/core_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module core_model (
	input wire logic clk, // Core clock
	output patch_pkg::word_t addr, // Fetch or read address
	output logic fetch, // Opcode fetch
	output logic read, // Data read
	output logic word, // Two-byte read
	output logic nosub // HL auto inc/dec read
);
	import patch_pkg::*;
	initial begin
		addr = 16'hFFFF;
		fetch = 1'b0;
		read = 1'b0;
		word = 1'b0;
		nosub = 1'b0;
	end
	// One access cycle; fetches aim at opcode starts, HL inc/dec reads flagged
	task automatic access(input word_t a, input logic [3:0] k);
		@(posedge clk);
		addr <= a;
		{fetch, read, word, nosub} <= k;
		@(posedge clk);
		// Idle bus shows the inverted address so a stale compare cannot pass
		addr <= ~a;
		{fetch, read, word, nosub} <= 4'h0;
	endtask
endmodule
`default_nettype wire

// ==== tb/rom_patch_unit_bench.sv ====
`timescale 1ns/1ns
`default_nettype none
module rom_patch_unit_bench;
	import patch_pkg::*;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h1;
	logic [31:0] dat_w = 32'h00000000;
	logic [31:0] dat_r;
	logic ack;
	word_t core_addr, jump_addr, subst_data;
	logic core_fetch, core_read, core_word, core_nosub, jump_req, subst_valid, trap_inhibit;
	int fails = 0;
	int num_checks = 0;
	word_t tbl [8];
	always #20 clk = ~clk;
	core_model core (.clk(clk), .addr(core_addr), .fetch(core_fetch), .read(core_read),
		.word(core_word), .nosub(core_nosub));
	rom_patch_unit DUT (.SYS_CLK(clk), .RSTN(rstn), .WB_CYC_I(cyc), .WB_STB_I(stb),
		.WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat_w), .WB_DAT_O(dat_r),
		.WB_ACK_O(ack), .CORE_ADDR(core_addr), .CORE_FETCH(core_fetch),
		.CORE_READ(core_read), .CORE_WORD(core_word), .CORE_NOSUB(core_nosub),
		.JUMP_REQ(jump_req), .JUMP_ADDR(jump_addr), .SUBST_VALID(subst_valid),
		.SUBST_DATA(subst_data), .TRAP_INHIBIT(trap_inhibit));
	task automatic end_sim();
		if (fails == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input byte_t d, output logic [31:0] q);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat_w <= {24'h000000, d};
		// Wait for ack; only the watchdog ends a wait that never gets an answer
		do begin
			@(posedge clk);
		end while (ack !== 1'b1);
		q = dat_r;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input byte_t d);
		logic [31:0] q;
		wb(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		wb(1'b0, a, BYTE_ZERO, q);
		num_checks++;
		if (q !== e) begin
			fails++;
			$display("MISMATCH %0t bus read %h got %h exp %h", $time, a, q, e);
		end
	endtask
	// Kind: 8 fetch, 4 byte read, 6 word read, 5 byte read with HL inc/dec
	task automatic probe(input word_t a, input logic [3:0] k, input logic [34:0] e);
		core.access(a, k);
		#1;
		num_checks++;
		if ({jump_req, jump_addr, subst_valid, subst_data, trap_inhibit} !== e) begin
			fails++;
			$display("MISMATCH %0t core access %h kind %h", $time, a, k);
		end
	endtask
	initial begin
		repeat (3000) @(posedge clk);
		fails++;
		$display("MISMATCH %0t watchdog timeout", $time);
		end_sim();
	end
	initial begin
		// Start addresses kept well apart, data banks point at constants
		tbl = '{16'hC020, 16'h0200, 16'hC030, 16'hCC33, 16'hC040, 16'h1234, 16'hC050, 16'h5678};
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		rd(OFS_PTR, 32'h00000000);
		rd(OFS_CTRL, 32'h00000000);
		wr(OFS_DATA, 8'h11);
		wr(OFS_DATA, 8'h22);
		rd(OFS_PTR, 32'h00000002);
		wr(OFS_PTR, 8'h07);
		rd(OFS_PTR, 32'h00000002);
		rd(8'h0C, 32'h00000000);
		// Lane 0 off: the byte is dropped and the pointer stays
		sel <= 4'h2;
		wr(OFS_DATA, 8'h33);
		sel <= 4'h1;
		rd(OFS_PTR, 32'h00000002);
		@(posedge clk);
		rstn <= 1'b0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		rd(OFS_PTR, 32'h00000000);
		for (int i = 0; i < 8; i++) begin
			wr(OFS_DATA, tbl[i][7:0]);
			wr(OFS_DATA, tbl[i][15:8]);
		end
		rd(OFS_PTR, 32'h00000000);
		rd(OFS_DATA, 32'h00000020);
		// Banks 1 and 3 replace data, 0 and 2 jump
		wr(OFS_CTRL, 8'hAF);
		rd(OFS_CTRL, 32'h000000AF);
		probe(16'hC020, 4'h8, {1'b1, 16'h0200, 1'b0, 16'h0000, 1'b0});
		// Patch code runs in RAM, then jumps back into ROM
		probe(16'h0200, 4'h8, {1'b0, 16'h0000, 1'b0, 16'h0000, 1'b1});
		probe(16'hC086, 4'h8, {1'b0, 16'h0000, 1'b0, 16'h0000, 1'b0});
		probe(16'hC040, 4'h8, {1'b1, 16'h1234, 1'b0, 16'h0000, 1'b0});
		probe(16'hC030, 4'h8, {1'b0, 16'h0000, 1'b0, 16'h0000, 1'b0});
		probe(16'hC020, 4'h6, {1'b0, 16'h0000, 1'b0, 16'h0000, 1'b0});
		probe(16'hC030, 4'h6, {1'b0, 16'h0000, 1'b1, 16'hCC33, 1'b0});
		probe(16'hC050, 4'h6, {1'b0, 16'h0000, 1'b1, 16'h5678, 1'b0});
		probe(16'hC030, 4'h4, {1'b0, 16'h0000, 1'b1, 16'h0033, 1'b0});
		probe(16'hC031, 4'h4, {1'b0, 16'h0000, 1'b0, 16'h0000, 1'b0});
		probe(16'hC031, 4'h6, {1'b0, 16'h0000, 1'b0, 16'h0000, 1'b0});
		probe(16'hC030, 4'h5, {1'b0, 16'h0000, 1'b0, 16'h0000, 1'b0});
		probe(16'h0140, 4'h8, {1'b0, 16'h0000, 1'b0, 16'h0000, 1'b1});
		probe(16'h023F, 4'h8, {1'b0, 16'h0000, 1'b0, 16'h0000, 1'b1});
		probe(16'h0240, 4'h8, {1'b0, 16'h0000, 1'b0, 16'h0000, 1'b0});
		probe(16'h013F, 4'h8, {1'b0, 16'h0000, 1'b0, 16'h0000, 1'b0});
		probe(16'h0140, 4'h4, {1'b0, 16'h0000, 1'b0, 16'h0000, 1'b0});
		wr(OFS_CTRL, 8'hAE);
		probe(16'hC020, 4'h8, {1'b0, 16'h0000, 1'b0, 16'h0000, 1'b0});
		probe(16'hC040, 4'h8, {1'b1, 16'h1234, 1'b0, 16'h0000, 1'b0});
		// Bank 0 alone, in data mode
		wr(OFS_CTRL, 8'h11);
		probe(16'hC020, 4'h6, {1'b0, 16'h0000, 1'b1, 16'h0200, 1'b0});
		probe(16'hC021, 4'h4, {1'b0, 16'h0000, 1'b0, 16'h0000, 1'b0});
		probe(16'hC020, 4'h8, {1'b0, 16'h0000, 1'b0, 16'h0000, 1'b0});
		probe(16'h0200, 4'h8, {1'b0, 16'h0000, 1'b0, 16'h0000, 1'b1});
		wr(OFS_CTRL, 8'h00);
		probe(16'h0140, 4'h8, {1'b0, 16'h0000, 1'b0, 16'h0000, 1'b0});
		probe(16'hC030, 4'h6, {1'b0, 16'h0000, 1'b0, 16'h0000, 1'b0});
		end_sim();
	end
endmodule
`default_nettype wire
